// ### rbl_pkg.sv
// Package of constants and carrier types for the reset boot loader
package rbl_pkg;

  // ---------------------------------------------------------------
  // Boot select encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] BOOT_DIRECT = 2'h0;
  localparam logic [1:0] BOOT_PFLASH = 2'h1;
  localparam logic [1:0] BOOT_SHOST = 2'h2;
  localparam logic [1:0] BOOT_SMEM = 2'h3;

  // ---------------------------------------------------------------
  // Addresses and header layout
  // ---------------------------------------------------------------
  localparam logic [31:0] EXT_EXEC_ADDR = 32'h2000_0000;
  localparam logic [31:0] IMEM_START_ADDR = 32'hffa0_0000;
  localparam logic [31:0] FLASH_BANK0_ADDR = 32'h2000_0000;
  localparam int HDR_BYTES = 10;
  localparam int HDR_FLAG_LO = 8;
  localparam int HDR_FLAG_HI = 9;
  localparam int FLAG_HOLD_LSB = 5;
  localparam int FLAG_HOLD_MSB = 10;
  localparam int FLAG_FINAL_BIT = 15;
  localparam int RCFG_NOBOOT_BIT = 4;

  // ---------------------------------------------------------------
  // External memory interface defaults (cycles)
  // ---------------------------------------------------------------
  localparam logic [3:0] EBIU_HOLD_CYC = 4'h3;
  localparam logic [3:0] EBIU_ACCESS_CYC = 4'hf;
  localparam logic [3:0] EBIU_SETUP_CYC = 4'h4;

  // ---------------------------------------------------------------
  // Serial memory command and register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SMEM_READ_CMD = 8'h03;
  localparam logic [7:0] SMEM_ADDR_BYTE = 8'h00;
  localparam logic [7:0] SMEM_IDLE_BYTE = 8'hff;
  localparam int SMEM_MAX_ADDR_BYTES = 3;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RCFG = 12'h008;
  localparam logic [11:0] REG_BYTES = 12'h00c;
  localparam logic [11:0] REG_ENTRY = 12'h010;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] hold;
    logic [3:0] access;
    logic [3:0] setup;
  } rbl_ebiu_cfg_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } rbl_wr_t;

endpackage : rbl_pkg

// ### rbl_spi_shift.sv
// Byte shifter for the boot serial port, master or slave, mode 0
`timescale 1ns/1ps
module rbl_spi_shift
  import rbl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic master,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  // Synchronised pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic miso_in,
  input wire logic mosi_in,
  // Results
  output logic sck_out,
  output logic mosi_out,
  output logic busy,
  output logic [7:0] rx_byte,
  output logic rx_done
);

  logic [7:0] sh_ff;
  logic [2:0] cnt_ff;
  logic [1:0] div_ff;
  logic sck_ff;
  logic sck_d_ff;
  logic busy_ff;
  logic bit_ff;

  assign sck_out = sck_ff;
  assign mosi_out = sh_ff[7];
  assign busy = busy_ff;
  assign rx_byte = sh_ff;

  // Slave mode samples on the rising edge of the host clock
  wire slave_rise = !master && !cs_n_in && sck_in && !sck_d_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_ff <= 8'h00;
      cnt_ff <= 3'h0;
      div_ff <= 2'h0;
      sck_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      busy_ff <= 1'b0;
      bit_ff <= 1'b0;
      rx_done <= 1'b0;
    end
    else if (ce)
    begin
      sck_d_ff <= sck_in;
      rx_done <= 1'b0;
      if (master)
      begin
        if (start && !busy_ff)
        begin
          sh_ff <= tx_byte;
          cnt_ff <= 3'h0;
          busy_ff <= 1'b1;
          div_ff <= 2'h0;
        end
        else if (busy_ff)
        begin
          div_ff <= div_ff + 2'h1;
          if (div_ff == 2'h3)
          begin
            sck_ff <= !sck_ff;
            // Sample on the rise, shift on the fall: the outgoing bit stands across the rise
            if (!sck_ff)
              bit_ff <= miso_in;
            else
            begin
              sh_ff <= {sh_ff[6:0], bit_ff};
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == 3'h7)
              begin
                busy_ff <= 1'b0;
                rx_done <= 1'b1;
              end
            end
          end
        end
      end
      else
      begin
        sck_ff <= 1'b0;
        busy_ff <= 1'b0;
        if (cs_n_in)
          cnt_ff <= 3'h0;
        else if (slave_rise)
        begin
          sh_ff <= {sh_ff[6:0], mosi_in};
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == 3'h7)
            rx_done <= 1'b1;
        end
      end
    end
  end

endmodule : rbl_spi_shift

// ### rbl_boot.sv
// Reset boot sequencer: boot select capture, header parse, block load
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps

module rbl_boot
  import rbl_pkg::*;
#(
  parameter int GPIO_W = 64
)
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot select pins
  input wire logic [1:0] boot_select_pins,
  // Parallel flash port, bank 0
  output logic [31:0] flash_addr,
  output logic flash_rd,
  output logic flash_bank0_sel_n,
  input wire logic [7:0] flash_data,
  input wire logic flash_ack,
  output rbl_ebiu_cfg_t ebiu_cfg,
  // Boot serial port
  input wire logic spi_sck_in,
  output logic spi_sck_out,
  output logic spi_sck_oe_n,
  input wire logic spi_cs_n_in,
  input wire logic spi_miso_in,
  input wire logic spi_mosi_in,
  output logic spi_mosi_out,
  output logic spi_miso_out,
  output logic spi_miso_oe_n,
  output logic serial_memory_select_flag,
  // Host hold flags, one per general purpose pin
  output logic [GPIO_W-1:0] host_hold_flag,
  output logic [GPIO_W-1:0] host_hold_oe_n,
  // Memory write port
  output rbl_wr_t mem_wr,
  // Core control
  output logic core_run,
  output logic [31:0] core_entry,
  output logic pack16
);

  typedef enum logic [7:0] {
    ST_CAPTURE = 8'b0000_0001,
    ST_DIRECT = 8'b0000_0010,
    ST_CMD = 8'b0000_0100,
    ST_PROBE = 8'b0000_1000,
    ST_HDR = 8'b0001_0000,
    ST_DATA = 8'b0010_0000,
    ST_RUN = 8'b0100_0000,
    ST_FETCH = 8'b1000_0000
  } rbl_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 6'h38;
      sync2_ff <= 6'h38;
    end
    else if (ce)
    begin
      sync1_ff <= {spi_cs_n_in, spi_miso_in, spi_mosi_in, spi_sck_in, boot_select_pins};
      sync2_ff <= sync1_ff;
    end
  end
  wire [1:0] bsel_s = sync2_ff[1:0];
  wire sck_s = sync2_ff[2];
  wire mosi_s = sync2_ff[3];
  wire miso_s = sync2_ff[4];
  wire cs_n_s = sync2_ff[5];

  // ---------------------------------------------------------------
  // State and registers
  // ---------------------------------------------------------------
  rbl_state_t state_ff;
  logic [1:0] mode_ff;
  logic [4:0] rcfg_ff;
  logic soft_rst_ff;
  logic [3:0] hcnt_ff;
  logic [7:0] hdr_ff [HDR_BYTES];
  logic [31:0] count_ff;
  logic [31:0] dst_ff;
  logic [31:0] src_ff;
  logic [1:0] probe_ff;
  logic [5:0] hold_sel_ff;
  logic busy_ff;
  logic rd_pend_ff;
  logic sh_start_ff;
  logic [7:0] sh_tx_ff;
  logic [31:0] loaded_ff;

  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;
  logic sh_sck;
  logic sh_mosi;

  function automatic logic [31:0] hdr_word(input int base);
    hdr_word = {hdr_ff[base+3], hdr_ff[base+2], hdr_ff[base+1], hdr_ff[base]};
  endfunction : hdr_word

  rbl_spi_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .master(mode_ff == BOOT_SMEM),
    .start(sh_start_ff),
    .tx_byte(sh_tx_ff),
    .sck_in(sck_s),
    .cs_n_in(cs_n_s),
    .miso_in(miso_s),
    .mosi_in(mosi_s),
    .sck_out(sh_sck),
    .mosi_out(sh_mosi),
    .busy(sh_busy),
    .rx_byte(sh_rx),
    .rx_done(sh_done)
  );

  // Byte source strobe common to all loading paths
  wire serial_mode = (mode_ff == BOOT_SHOST) || (mode_ff == BOOT_SMEM);
  wire byte_ok = serial_mode ? sh_done : (rd_pend_ff && flash_ack);
  wire [7:0] byte_in = serial_mode ? sh_rx : flash_data;
  wire final_blk = hdr_ff[HDR_FLAG_HI][FLAG_FINAL_BIT-8];
  wire apb_wr = psel && penable && pwrite;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_CAPTURE;
      mode_ff <= BOOT_DIRECT;
      hcnt_ff <= 4'h0;
      count_ff <= 32'h0;
      dst_ff <= 32'h0;
      src_ff <= 32'h0;
      probe_ff <= 2'h0;
      hold_sel_ff <= 6'h00;
      rd_pend_ff <= 1'b0;
      sh_start_ff <= 1'b0;
      sh_tx_ff <= SMEM_IDLE_BYTE;
      mem_wr <= '0;
      loaded_ff <= 32'h0;
      for (int i = 0; i < HDR_BYTES; i++)
        hdr_ff[i] <= 8'h00;
    end
    else if (ce)
    begin
      mem_wr.valid <= 1'b0;
      sh_start_ff <= 1'b0;
      if (soft_rst_ff)
        state_ff <= ST_CAPTURE;
      else
        case (state_ff)
          ST_CAPTURE:
          begin
            mode_ff <= bsel_s;
            hcnt_ff <= 4'h0;
            loaded_ff <= 32'h0;
            src_ff <= FLASH_BANK0_ADDR;
            if (rcfg_ff[RCFG_NOBOOT_BIT])
              state_ff <= ST_RUN;
            else if (bsel_s == BOOT_DIRECT)
              state_ff <= ST_FETCH;
            else if (bsel_s == BOOT_SMEM)
              state_ff <= ST_CMD;
            else
              state_ff <= ST_HDR;
          end
          ST_CMD:
          begin
            if (!sh_busy && !sh_start_ff)
            begin
              sh_tx_ff <= SMEM_READ_CMD;
              sh_start_ff <= 1'b1;
              probe_ff <= 2'h0;
              state_ff <= ST_PROBE;
            end
          end
          ST_PROBE:
          begin
            // Keep sending zero address bytes until the memory drives data
            if (sh_done && probe_ff != 2'h0 && sh_rx != SMEM_IDLE_BYTE)
            begin
              hdr_ff[0] <= sh_rx;
              hcnt_ff <= 4'h1;
              state_ff <= ST_HDR;
            end
            else if (!sh_busy && !sh_start_ff)
            begin
              sh_tx_ff <= SMEM_ADDR_BYTE;
              sh_start_ff <= 1'b1;
              if (probe_ff != 2'(SMEM_MAX_ADDR_BYTES))
                probe_ff <= probe_ff + 2'h1;
            end
          end
          ST_HDR:
          begin
            if (byte_ok)
            begin
              hdr_ff[hcnt_ff] <= byte_in;
              src_ff <= src_ff + 32'h1;
              rd_pend_ff <= 1'b0;
              if (hcnt_ff == 4'(HDR_BYTES - 1))
              begin
                hcnt_ff <= 4'h0;
                state_ff <= ST_DATA;
              end
              else
                hcnt_ff <= hcnt_ff + 4'h1;
            end
            else if (mode_ff == BOOT_PFLASH)
              rd_pend_ff <= 1'b1;
            if (mode_ff == BOOT_SMEM && !sh_busy && !sh_start_ff && !byte_ok)
            begin
              sh_tx_ff <= SMEM_IDLE_BYTE;
              sh_start_ff <= 1'b1;
            end
          end
          ST_DATA:
          begin
            if (hcnt_ff == 4'h0)
            begin
              // Bytes 0-3 destination, 4-7 count, 8-9 flag word
              dst_ff <= hdr_word(0);
              count_ff <= hdr_word(4);
              hold_sel_ff <= {hdr_ff[HDR_FLAG_HI][FLAG_HOLD_MSB-8:0],
                hdr_ff[HDR_FLAG_LO][7:FLAG_HOLD_LSB]};
              hcnt_ff <= 4'h1;
            end
            else if (count_ff == 32'h0)
            begin
              hcnt_ff <= 4'h0;
              state_ff <= final_blk ? ST_RUN : ST_HDR;
            end
            else
            begin
              if (byte_ok)
              begin
                mem_wr.valid <= 1'b1;
                mem_wr.addr <= dst_ff;
                mem_wr.data <= byte_in;
                dst_ff <= dst_ff + 32'h1;
                src_ff <= src_ff + 32'h1;
                count_ff <= count_ff - 32'h1;
                loaded_ff <= loaded_ff + 32'h1;
                rd_pend_ff <= 1'b0;
              end
              else if (mode_ff == BOOT_PFLASH)
                rd_pend_ff <= 1'b1;
              if (mode_ff == BOOT_SMEM && !sh_busy && !sh_start_ff && !byte_ok
                  && count_ff != 32'h1)
              begin
                sh_tx_ff <= SMEM_IDLE_BYTE;
                sh_start_ff <= 1'b1;
              end
            end
          end
          ST_RUN: state_ff <= ST_RUN;
          ST_FETCH: state_ff <= ST_FETCH;
          default: state_ff <= ST_CAPTURE;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs toward memory, serial port and core
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_addr <= 32'h0;
      flash_rd <= 1'b0;
      flash_bank0_sel_n <= 1'b1;
      ebiu_cfg <= '0;
      spi_sck_out <= 1'b0;
      spi_sck_oe_n <= 1'b1;
      spi_mosi_out <= 1'b1;
      spi_miso_out <= 1'b0;
      spi_miso_oe_n <= 1'b1;
      serial_memory_select_flag <= 1'b1;
      host_hold_flag <= '0;
      host_hold_oe_n <= '1;
      core_run <= 1'b0;
      core_entry <= IMEM_START_ADDR;
      pack16 <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (ce)
    begin
      ebiu_cfg <= '{hold: EBIU_HOLD_CYC, access: EBIU_ACCESS_CYC,
        setup: EBIU_SETUP_CYC};
      flash_rd <= (mode_ff == BOOT_PFLASH) && rd_pend_ff && !flash_ack;
      flash_addr <= src_ff;
      flash_bank0_sel_n <= !((mode_ff == BOOT_PFLASH) && rd_pend_ff);
      // Master drives the clock, slave leaves the pins to the host
      spi_sck_out <= sh_sck;
      spi_mosi_out <= sh_mosi;
      spi_sck_oe_n <= !(mode_ff == BOOT_SMEM && state_ff != ST_CAPTURE);
      spi_miso_oe_n <= 1'b1;
      serial_memory_select_flag <= !(mode_ff == BOOT_SMEM
        && (state_ff == ST_CMD || state_ff == ST_PROBE
        || state_ff == ST_HDR || state_ff == ST_DATA));
      // Busy while a byte is digested, the header is decoded or the boot select is captured
      busy_ff <= (state_ff == ST_DATA && hcnt_ff == 4'h0) || byte_ok
        || state_ff == ST_CAPTURE;
      for (int i = 0; i < GPIO_W; i++)
      begin
        host_hold_flag[i] <= (mode_ff == BOOT_SHOST) && (hold_sel_ff == 6'(i))
          && (busy_ff || state_ff == ST_RUN);
        host_hold_oe_n[i] <= !((mode_ff == BOOT_SHOST) && (hold_sel_ff == 6'(i)));
      end
      core_run <= (state_ff == ST_RUN) || (state_ff == ST_FETCH);
      core_entry <= (state_ff == ST_FETCH) ? EXT_EXEC_ADDR : IMEM_START_ADDR;
      pack16 <= (state_ff == ST_FETCH);
    end
  end

  // ---------------------------------------------------------------
  // APB slave: control, status, reset configuration
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcfg_ff <= 5'h00;
      soft_rst_ff <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      soft_rst_ff <= 1'b0;
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          REG_CTRL: prdata <= 32'h0;
          REG_STATUS: prdata <= {14'h0, hold_sel_ff, mode_ff, state_ff, 2'h0};
          REG_RCFG: prdata <= {27'h0, rcfg_ff};
          REG_BYTES: prdata <= loaded_ff;
          REG_ENTRY: prdata <= core_entry;
          default:
          begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apb_wr && pready)
      begin
        if (paddr == REG_RCFG)
          rcfg_ff <= pwdata[4:0];
        if (paddr == REG_CTRL && pwdata[CTRL_RESET])
          soft_rst_ff <= 1'b1;
      end
    end
  end

endmodule : rbl_boot

// ### rbl_img.svh
// Loader image shared by the flash answerer and the serial host model
// No guard: every module that includes this needs its own copy of the function
// Two blocks: 2 bytes to 0xffa0_0000, then a final 1 byte to 0xffa0_0010, hold pin 7
function automatic logic [7:0] rbl_img(input int i);
  logic [7:0] t [0:22];
  t = '{8'h00, 8'h00, 8'ha0, 8'hff, 8'h02, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'hca, 8'hcb,
    8'h10, 8'h00, 8'ha0, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'he0, 8'h80, 8'hd6};
  return t[i];
endfunction : rbl_img

// ### rbl_chk.sv
// Port assertions for the reset boot loader
`timescale 1ns/1ps
module rbl_chk
  import rbl_pkg::*;
#(
  parameter int GPIO_W = 64
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_rd,
  input wire logic flash_ack,
  input wire logic [31:0] flash_addr,
  input wire logic flash_bank0_sel_n,
  input wire rbl_ebiu_cfg_t ebiu_cfg,
  input wire logic spi_sck_oe_n,
  input wire logic spi_miso_oe_n,
  input wire logic serial_memory_select_flag,
  input wire logic [GPIO_W-1:0] host_hold_oe_n,
  input wire rbl_wr_t mem_wr,
  input wire logic core_run,
  input wire logic [31:0] core_entry,
  input wire logic pack16
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready && psel && penable;
  endsequence
  sequence s_running;
    core_run [*4];
  endsequence
  property p_apb_ready;
    s_setup |=> s_answer;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer missing");
  property p_err_pair;
    pslverr |-> pready;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("error without ready");
  property p_ebiu;
    $past(presetn) |-> ebiu_cfg == {EBIU_HOLD_CYC, EBIU_ACCESS_CYC, EBIU_SETUP_CYC};
  endproperty
  a_ebiu: assert property (p_ebiu) else $error("memory timing defaults wrong");
  property p_bank0;
    flash_rd |-> !flash_bank0_sel_n;
  endproperty
  a_bank0: assert property (p_bank0) else $error("flash read off bank 0");
  property p_rd_hold;
    flash_rd && !flash_ack |=> flash_rd && $stable(flash_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("flash read dropped");
  property p_entry;
    core_run |-> core_entry == (pack16 ? EXT_EXEC_ADDR : IMEM_START_ADDR);
  endproperty
  a_entry: assert property (p_entry) else $error("entry address wrong");
  property p_run_quiet;
    core_run |-> !mem_wr.valid && !flash_rd;
  endproperty
  a_run_quiet: assert property (p_run_quiet) else $error("load after run");
  property p_run_stays;
    $rose(core_run) |-> s_running;
  endproperty
  a_run_stays: assert property (p_run_stays) else $error("run not held");
  property p_smem_sel;
    !serial_memory_select_flag |-> !spi_sck_oe_n;
  endproperty
  a_smem_sel: assert property (p_smem_sel) else $error("select without clock");
  property p_miso_off;
    spi_miso_oe_n;
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("slave drove miso");
  property p_one_hold;
    $countones(~host_hold_oe_n) <= 1;
  endproperty
  a_one_hold: assert property (p_one_hold) else $error("several hold pins");
endmodule : rbl_chk

bind rbl_boot rbl_chk #(.GPIO_W(GPIO_W)) rbl_chk_i (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .flash_rd, .flash_ack, .flash_addr, .flash_bank0_sel_n, .ebiu_cfg,
  .spi_sck_oe_n, .spi_miso_oe_n, .serial_memory_select_flag, .host_hold_oe_n, .mem_wr,
  .core_run, .core_entry, .pack16);

// ### rbl_host_model.sv
// Serial host that streams the loader image into the boot serial port
`timescale 1ns/1ps
module rbl_host_model
(
  // Control
  input wire logic go,
  input wire logic hold,
  // Serial pins
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  `include "rbl_img.svh"
  localparam int HALF_NS = 40;
  logic [7:0] by;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ----
  // Byte stream; clock idles low between bytes
  // ----
  always @(posedge go)
  begin
    cs_n = 1'b0;
    for (int i = 0; i < 23; i++)
    begin
      #64;
      while (hold === 1'b1) #8;
      by = rbl_img(i);
      for (int b = 7; b >= 0; b--)
      begin
        mosi = by[b];
        #HALF_NS sck = 1'b1;
        #HALF_NS sck = 1'b0;
      end
      // Released line shows the inverse so a stale bit cannot pass
      mosi = ~mosi;
    end
    cs_n = 1'b1;
  end
endmodule : rbl_host_model

// ### testbench.sv
// Self-checking bench for the reset boot loader
`timescale 1ns/1ps
module testbench
  import rbl_pkg::*;
;
  `include "rbl_img.svh"
  logic pclk, presetn, psel, penable, pwrite, flash_ack, go, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata, flash_addr, core_entry;
  logic [1:0] boot_select_pins;
  logic [7:0] flash_data;
  logic pready, pslverr, flash_rd, flash_bank0_sel_n, spi_sck_out, spi_sck_oe_n;
  logic spi_mosi_out, spi_miso_out, spi_miso_oe_n, serial_memory_select_flag;
  logic core_run, pack16;
  logic [63:0] host_hold_flag, host_hold_oe_n;
  rbl_ebiu_cfg_t ebiu_cfg;
  rbl_wr_t mem_wr;
  rbl_wr_t wq[$];
  wire logic hsck, hcs_n, hmosi;
  wire logic sck_w = !spi_sck_oe_n ? spi_sck_out : hsck;
  wire logic hold_w = |(host_hold_flag & ~host_hold_oe_n);
  int miscompares = 0;
  int total_checks = 0;
  int fd = 0;

  rbl_boot #(.GPIO_W(64)) rbl_boot_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_select_pins, .flash_addr, .flash_rd,
    .flash_bank0_sel_n, .flash_data, .flash_ack, .ebiu_cfg, .spi_sck_in(sck_w),
    .spi_sck_out, .spi_sck_oe_n, .spi_cs_n_in(hcs_n), .spi_miso_in(1'b1),
    .spi_mosi_in(hmosi), .spi_mosi_out, .spi_miso_out, .spi_miso_oe_n,
    .serial_memory_select_flag, .host_hold_flag, .host_hold_oe_n, .mem_wr, .core_run,
    .core_entry, .pack16);
  rbl_host_model rbl_host_model_i (.go, .hold(hold_w), .sck(hsck), .cs_n(hcs_n), .mosi(hmosi));

  always #4 pclk = ~pclk;
  // ----
  // Flash answerer, two wait cycles per byte; idle bus toggles
  // ----
  always @(posedge pclk)
  begin
    flash_ack <= 1'b0;
    if (flash_rd === 1'b1 && flash_ack !== 1'b1 && fd == 2)
    begin
      flash_ack <= 1'b1;
      flash_data <= rbl_img(int'(flash_addr - FLASH_BANK0_ADDR));
      fd <= 0;
    end
    else
    begin
      flash_data <= ~flash_data;
      if (flash_rd === 1'b1 && flash_ack !== 1'b1)
        fd <= fd + 1;
    end
    if (mem_wr.valid === 1'b1)
      wq.push_back(mem_wr);
  end
  // ----
  // Shared tasks
  // ----
  task wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task hang;
    miscompares++;
    wrap_up();
  endtask : hang
  task check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_run(input int lim);
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    while (core_run !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
      hang();
  endtask : wait_run
  // Pins settle through the sync stages, so a software reset makes the real capture
  task boot(input logic [1:0] m);
    @(posedge pclk);
    boot_select_pins <= m;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    wq.delete();
    apb(1'b1, REG_CTRL, 32'h1);
  endtask : boot
  task chk_load;
    wait_run(30000);
    check(wq.size(), 3);
    for (int i = 0; i < 3; i++)
      check({wq[i].addr, wq[i].data},
        {IMEM_START_ADDR + ((i == 2) ? 32'h10 : i), rbl_img((i == 2) ? 22 : 10 + i)});
    check(core_entry, IMEM_START_ADDR);
    check(pack16, 1'b0);
  endtask : chk_load
  // ----
  // Scenarios
  // ----
  task t_direct;
    boot(BOOT_DIRECT);
    wait_run(300);
    check(core_entry, EXT_EXEC_ADDR);
    check(pack16, 1'b1);
    check(ebiu_cfg, {EBIU_HOLD_CYC, EBIU_ACCESS_CYC, EBIU_SETUP_CYC});
    check(wq.size(), 0);
  endtask : t_direct
  task t_flash;
    boot(BOOT_PFLASH);
    chk_load();
    check(ebiu_cfg, {EBIU_HOLD_CYC, EBIU_ACCESS_CYC, EBIU_SETUP_CYC});
  endtask : t_flash
  task t_skip;
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[11:10], BOOT_PFLASH);
    apb(1'b0, 12'hffc, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, REG_RCFG, 32'h10);
    apb(1'b0, REG_RCFG, 32'h0);
    check(rd[4:0], 5'h10);
    wq.delete();
    apb(1'b1, REG_CTRL, 32'h1);
    wait_run(300);
    check(wq.size(), 0);
    check(core_entry, IMEM_START_ADDR);
    apb(1'b1, REG_RCFG, 32'h0);
  endtask : t_skip
  task t_smem;
    logic [15:0] sh;
    logic last;
    int n;
    int bits;
    boot(BOOT_SMEM);
    n = 0;
    bits = 0;
    last = 1'b0;
    while (bits < 16 && n < 4000)
    begin
      @(posedge pclk);
      n++;
      if (spi_sck_out === 1'b1 && last === 1'b0)
      begin
        sh = {sh[14:0], spi_mosi_out};
        bits++;
      end
      last = spi_sck_out;
    end
    if (bits < 16)
      hang();
    check(sh, {SMEM_READ_CMD, SMEM_ADDR_BYTE});
    check(serial_memory_select_flag, 1'b0);
    check(spi_sck_oe_n, 1'b0);
  endtask : t_smem
  task t_host;
    boot(BOOT_SHOST);
    repeat (8) @(posedge pclk);
    go <= 1'b1;
    chk_load();
    check(host_hold_oe_n, ~(64'h1 << 7));
    check(host_hold_flag[7], 1'b1);
    go <= 1'b0;
  endtask : t_host

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    boot_select_pins = 2'h0;
    flash_ack = 1'b0;
    flash_data = 8'h00;
    go = 1'b0;
    t_direct();
    t_flash();
    t_skip();
    t_smem();
    t_host();
    wrap_up();
  end
endmodule : testbench
